// ===== inc/osc_select_pkg.sv
// Purpose: Shared constants and types for the oscillator source selection block.
// Assumes: Avalon-MM byte addresses, 8-bit registers in the low byte of each word.
// Notes: Oscillator activity arrives as one-cycle tick pulses on the 100 MHz clock.
//
// Overview of operation
// - Low-power bit 0 runs slow crystal in quick-start mode, 1 in low-power mode.
// - Source code 0101010 picks slow RC, 1010101 slow crystal; others reset the MCU.
// - After reset the low-power bit is zero, so the slow crystal quick-starts.
// - Slow crystal keeps oscillating whatever the low-power setting is.
// - Exactly one fast and one slow oscillator are always selected.
// - Fast/slow bit and divider field pick the system clock, changeable at run time.
// - Options pick the fast crystal and mark its range as at least or below 1 MHz.
// - Slow crystal pins are ordinary I/O whenever the slow crystal is unused.
// - With the fast RC selected the fast crystal pins stay ordinary I/O.
// - Sources: fast RC 8 MHz, fast crystal 400 kHz-16 MHz, slow RC 32 kHz, crystal 32.768 kHz.
// - The oscillators also clock the watchdog and the time-base logic.
// - Sleep, or idle without fsys_keep, stops the system clock; a slow clock may keep timers running.
// - Divider codes 000/001 pick sub clock; 010..111 pick fast divided by 64 down to 2.
// - Slow ready flag rises 1024 cycles after wake on crystal, 1 to 2 on RC.
package osc_select_pkg;

  // Register byte offsets
  localparam logic [3:0] SUB_CTRL_OFFSET = 4'h0;
  localparam logic [3:0] SYS_MODE_OFFSET = 4'h4;
  localparam logic [3:0] CLK_CFG_OFFSET = 4'h8;

  // Reset values
  localparam logic [7:0] SUB_CTRL_RESET = 8'h2a;
  localparam logic [7:0] SYS_MODE_RESET = 8'h03;
  localparam logic [7:0] CLK_CFG_RESET = 8'h00;

  // Sub clock control fields
  localparam int LOW_POWER_BIT = 7;
  localparam int SRC_CODE_MSB = 6;
  localparam logic [6:0] CODE_SLOW_RC = 7'h2a;
  localparam logic [6:0] CODE_SLOW_XTAL = 7'h55;

  // System mode fields
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 5;
  localparam int READY_BIT = 3;
  localparam int FAST_READY_BIT = 2;
  localparam int IDLE_BIT = 1;
  localparam int FAST_SLOW_BIT = 0;
  localparam logic [2:0] DIV_SUB_MAX = 3'h1;

  // Clock option fields
  localparam int CFG_FAST_XTAL_BIT = 0;
  localparam int CFG_HIGH_RANGE_BIT = 1;

  // Ready delays in sub clock cycles
  localparam int SLOW_XTAL_READY_CYCLES = 1024;
  localparam int SLOW_RC_READY_CYCLES = 2;

  // Nominal source rates in Hz
  localparam int CLK_HZ = 100_000_000;
  localparam int FAST_RC_HZ = 8_000_000;
  localparam int FAST_XTAL_MIN_HZ = 400_000;
  localparam int FAST_XTAL_MAX_HZ = 16_000_000;
  localparam int FAST_XTAL_SPLIT_HZ = 1_000_000;
  localparam int SLOW_RC_HZ = 32_000;
  localparam int SLOW_XTAL_HZ = 32_768;

  // One bit per oscillator, used for ticks and enables
  typedef struct packed {
    logic fast_rc;
    logic fast_xtal;
    logic slow_rc;
    logic slow_xtal;
  } osc_set_type;

  // Sub clock source switch states
  typedef enum logic [0:0] {SUB_RUN, SUB_SWITCH} sub_state_type;

endpackage : osc_select_pkg

// ===== src/ready_timer.sv
// Purpose: Counts sub clock ticks after a restart and raises a ready level.
// Assumes: Tick is a one-cycle pulse on clk.
// Notes: Restart held high keeps the flag low.
`timescale 1ns/100ps
`default_nettype none
module ready_timer import osc_select_pkg::*; #(
  parameter int CNT_W = 11
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic restart, // Hold low and restart count
  input wire logic tick, // Oscillator tick
  input wire logic [CNT_W-1:0] target, // Ticks needed
  output logic ready // Oscillator stable
);

  logic [CNT_W-1:0] cnt_ff;
  logic ready_ff;
  wire logic reach = (cnt_ff == target);
  wire logic [CNT_W-1:0] nxt_cnt = (tick && !reach) ? cnt_ff + 1'b1 : cnt_ff;

  // Count stops at target so the flag cannot wrap back low
  always_ff @(posedge clk) begin
    if (srst || restart) begin
      cnt_ff <= '0;
      ready_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      ready_ff <= reach;
    end
  end

  assign ready = ready_ff;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  a_ready_count: assert property ($rose(ready_ff) |-> $past(cnt_ff) == target)
    else $error("ready flag rose before the tick count was reached");

endmodule : ready_timer
`default_nettype wire

// ===== src/oscillator_source_select.sv
// Purpose: Selects fast and slow oscillator sources and derives system, sub,
//          watchdog and time-base clock enables.
// Assumes: Oscillator activity arrives as one-cycle ticks on clk.
// Notes: Registers sit on an Avalon-MM slave with one wait state per access.
`timescale 1ns/100ps
`default_nettype none
module oscillator_source_select import osc_select_pkg::*; #(
  parameter int XTAL_READY = SLOW_XTAL_READY_CYCLES,
  parameter int RC_READY = SLOW_RC_READY_CYCLES
) (
  input wire logic clk, // System clock, 100 MHz
  input wire logic srst, // Synchronous reset
  input wire logic [3:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire osc_set_type osc_tick, // Oscillator tick pulses
  input wire logic halt_active, // CPU halted
  input wire logic fsys_keep, // Keep system clock in idle
  input wire logic wdt_enabled, // Watchdog on
  output osc_set_type osc_enable, // Oscillator enables
  output logic slow_crystal_low_power_sel, // Slow crystal low power
  output logic slow_crystal_pins_gpio, // Slow crystal pins free
  output logic fast_crystal_pins_gpio, // Fast crystal pins free
  output logic fast_xtal_high_range, // Fast crystal 1 MHz or more
  output logic sys_clock_en, // System clock tick
  output logic sub_clock_en, // Sub clock tick
  output logic wdt_clock_en, // Watchdog clock tick
  output logic timebase_clock_en, // Time-base clock tick
  output logic slow_osc_ready_flag, // Slow oscillator ready
  output logic mcu_reset_req // Reset request pulse
);

  // Accepts only the two legal source codes
  function automatic logic code_valid(input logic [6:0] code);
    code_valid = (code == CODE_SLOW_RC) || (code == CODE_SLOW_XTAL);
  endfunction : code_valid

  // Divider mask: all ones in the mask marks the divided tick
  function automatic logic [5:0] div_mask(input logic fast_slow, input logic [2:0] div);
    logic [5:0] m;
    m = 6'h00;
    if (!fast_slow) begin
      unique case (div)
        3'h7: m = 6'h01;
        3'h6: m = 6'h03;
        3'h5: m = 6'h07;
        3'h4: m = 6'h0f;
        3'h3: m = 6'h1f;
        default: m = 6'h3f;
      endcase
    end
    div_mask = m;
  endfunction : div_mask

  logic ack_ff;
  logic [31:0] readdata_ff;
  logic [7:0] sub_ctrl_ff;
  logic [7:0] sys_mode_ff;
  logic [7:0] clk_cfg_ff;
  logic bad_code_ff;
  logic [5:0] fdiv_cnt_ff;
  logic fast_ready_ff;
  logic active_xtal_ff;
  sub_state_type sub_state_ff;
  logic ready_w;

  // Bus handshake: one wait state, then the access completes
  wire logic bus_req = avs_read || avs_write;
  wire logic bus_done = bus_req && ack_ff;
  wire logic nxt_ack = bus_req && !ack_ff;
  assign avs_waitrequest = bus_req && !ack_ff;
  assign avs_readdata = readdata_ff;

  // Write decode
  wire logic lane0_wr = avs_write && bus_done && avs_byteenable[0];
  wire logic wr_sub = lane0_wr && (avs_address == SUB_CTRL_OFFSET);
  wire logic wr_mode = lane0_wr && (avs_address == SYS_MODE_OFFSET);
  wire logic wr_cfg = lane0_wr && (avs_address == CLK_CFG_OFFSET);
  wire logic wr_code_ok = code_valid(avs_writedata[SRC_CODE_MSB:0]);
  wire logic bad_code = wr_sub && !wr_code_ok;

  // Only legal codes are stored, so one slow source stays selected
  wire logic [7:0] nxt_sub_ctrl = (wr_sub && wr_code_ok) ? avs_writedata[7:0] : sub_ctrl_ff;
  // Ready flags are read-only and bit 4 is unimplemented
  wire logic [7:0] mode_wmask = 8'he3;
  wire logic [7:0] nxt_sys_mode = wr_mode ? (avs_writedata[7:0] & mode_wmask) : sys_mode_ff;
  wire logic [7:0] nxt_clk_cfg = wr_cfg ? (avs_writedata[7:0] & 8'h03) : clk_cfg_ff;

  // Field decode
  wire logic sel_xtal = (sub_ctrl_ff[SRC_CODE_MSB:0] == CODE_SLOW_XTAL);
  wire logic fast_slow = sys_mode_ff[FAST_SLOW_BIT];
  wire logic [2:0] div_sel = sys_mode_ff[DIV_MSB:DIV_LSB];
  wire logic idle_sel = sys_mode_ff[IDLE_BIT];
  wire logic cfg_fast_xtal = clk_cfg_ff[CFG_FAST_XTAL_BIT];
  wire logic fast_mode = fast_slow || (div_sel > DIV_SUB_MAX);

  // Power modes
  wire logic sleep_any = halt_active && !idle_sel;
  wire logic sleep0 = sleep_any && !wdt_enabled;
  wire logic idle1 = halt_active && idle_sel && fsys_keep;
  wire logic sys_run = !halt_active || idle1;
  wire logic sub_running = !sleep0;
  wire logic fast_needed = fast_mode && sys_run;

  // Read mux, unmapped addresses read zero
  wire logic [7:0] mode_view = {sys_mode_ff[7:4], ready_w, fast_ready_ff, sys_mode_ff[1:0]};
  wire logic [7:0] rd_byte = (avs_address == SUB_CTRL_OFFSET) ? sub_ctrl_ff :
                             (avs_address == SYS_MODE_OFFSET) ? mode_view :
                             (avs_address == CLK_CFG_OFFSET) ? clk_cfg_ff : 8'h00;
  wire logic [31:0] nxt_readdata = (avs_read && !ack_ff) ? {24'h000000, rd_byte} : readdata_ff;

  // Bus acknowledge and read capture
  always_ff @(posedge clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      readdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= nxt_ack;
      readdata_ff <= nxt_readdata;
    end
  end

  // Control registers; an illegal code behaves like a reset of them
  always_ff @(posedge clk) begin
    if (srst || bad_code) begin
      sub_ctrl_ff <= SUB_CTRL_RESET;
      sys_mode_ff <= SYS_MODE_RESET;
      clk_cfg_ff <= CLK_CFG_RESET;
    end else begin
      sub_ctrl_ff <= nxt_sub_ctrl;
      sys_mode_ff <= nxt_sys_mode;
      clk_cfg_ff <= nxt_clk_cfg;
    end
  end

  // Reset request is a one-cycle pulse after the offending write
  always_ff @(posedge clk) begin
    if (srst) begin
      bad_code_ff <= 1'b0;
    end else begin
      bad_code_ff <= bad_code;
    end
  end
  assign mcu_reset_req = bad_code_ff;

  // Slow crystal mode and pin use follow the register
  assign slow_crystal_low_power_sel = sub_ctrl_ff[LOW_POWER_BIT];
  assign slow_crystal_pins_gpio = !(sel_xtal || active_xtal_ff);
  assign fast_crystal_pins_gpio = !cfg_fast_xtal;
  assign fast_xtal_high_range = clk_cfg_ff[CFG_HIGH_RANGE_BIT];

  // Sub clock switch: after a source change the first tick of the new
  // source is swallowed, so no period is shorter than a full one
  wire logic switching = (sub_state_ff == SUB_SWITCH);
  wire logic new_tick = sel_xtal ? osc_tick.slow_xtal : osc_tick.slow_rc;
  wire logic sub_raw = active_xtal_ff ? osc_tick.slow_xtal : osc_tick.slow_rc;
  sub_state_type nxt_sub_state;
  logic nxt_active_xtal;
  always_comb begin
    nxt_sub_state = sub_state_ff;
    nxt_active_xtal = active_xtal_ff;
    unique case (sub_state_ff)
      SUB_RUN: begin
        if (sel_xtal != active_xtal_ff) begin
          nxt_sub_state = SUB_SWITCH;
        end
      end
      SUB_SWITCH: begin
        if (sel_xtal == active_xtal_ff) begin
          nxt_sub_state = SUB_RUN;
        end else if (new_tick) begin
          nxt_sub_state = SUB_RUN;
          nxt_active_xtal = sel_xtal;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sub_state_ff <= SUB_RUN;
      active_xtal_ff <= 1'b0;
    end else begin
      sub_state_ff <= nxt_sub_state;
      active_xtal_ff <= nxt_active_xtal;
    end
  end

  // Oscillator enables; slow crystal runs in either power mode
  assign osc_enable.fast_rc = fast_needed && !cfg_fast_xtal;
  assign osc_enable.fast_xtal = fast_needed && cfg_fast_xtal;
  assign osc_enable.slow_rc = sub_running && (!sel_xtal || !active_xtal_ff);
  assign osc_enable.slow_xtal = sub_running && (sel_xtal || active_xtal_ff);

  // Fast prescaler counts ticks of whichever fast source is enabled
  wire logic fast_tick = cfg_fast_xtal ? osc_tick.fast_xtal : osc_tick.fast_rc;
  wire logic [5:0] cur_mask = div_mask(fast_slow, div_sel);
  wire logic fdiv_pulse = fast_tick && ((fdiv_cnt_ff & cur_mask) == cur_mask);
  wire logic [5:0] nxt_fdiv_cnt = !fast_needed ? 6'h00 : (fast_tick ? fdiv_cnt_ff + 6'h01 : fdiv_cnt_ff);
  wire logic nxt_fast_ready = fast_needed && (fast_ready_ff || fast_tick);

  always_ff @(posedge clk) begin
    if (srst) begin
      fdiv_cnt_ff <= 6'h00;
      fast_ready_ff <= 1'b0;
    end else begin
      fdiv_cnt_ff <= nxt_fdiv_cnt;
      fast_ready_ff <= nxt_fast_ready;
    end
  end

  // Clock enables to the rest of the chip
  assign sub_clock_en = sub_running && !switching && sub_raw;
  assign sys_clock_en = sys_run && (fast_mode ? fdiv_pulse : sub_clock_en);
  assign wdt_clock_en = sub_clock_en && wdt_enabled;
  assign timebase_clock_en = sub_clock_en && !sleep_any;

  // Ready flag restarts while stopped and after each source change
  wire logic ready_restart = sleep0 || switching;
  wire logic [10:0] ready_target = active_xtal_ff ? 11'(XTAL_READY) : 11'(RC_READY);

  ready_timer #(
    .CNT_W(11)
  ) u_ready (
    .clk(clk),
    .srst(srst),
    .restart(ready_restart),
    .tick(sub_raw),
    .target(ready_target),
    .ready(ready_w)
  );
  assign slow_osc_ready_flag = ready_w;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence seq_switch_begin;
    (sub_state_ff == SUB_RUN) && (sel_xtal != active_xtal_ff) ##1 (sub_state_ff == SUB_SWITCH);
  endsequence

  sequence seq_good_write;
    wr_sub && wr_code_ok;
  endsequence

  a_low_power_write: assert property (seq_good_write |=> slow_crystal_low_power_sel == $past(avs_writedata[7]))
    else $error("low power select did not follow the written bit");

  a_bad_code_reset: assert property (bad_code |=> mcu_reset_req && sub_ctrl_ff == SUB_CTRL_RESET)
    else $error("illegal source code did not reset");

  a_reset_quick_start: assert property (@(posedge clk) disable iff (1'b0) srst |=> !slow_crystal_low_power_sel)
    else $error("low power select not cleared by reset");

  // Both slow sources run while a switch is pending, and none in the deepest sleep
  a_one_slow_source: assert property (code_valid(sub_ctrl_ff[6:0]) && (sleep0 || (sel_xtal != active_xtal_ff)
                                      || $onehot(osc_enable[1:0])))
    else $error("slow source selection is not exactly one");

  a_xtal_keeps_running: assert property (sub_running && sel_xtal |-> osc_enable.slow_xtal)
    else $error("slow crystal stopped while selected");

  a_slow_sys_clock: assert property (!halt_active && !fast_mode |-> sys_clock_en == sub_clock_en)
    else $error("slow mode does not use the sub clock");

  a_div_by_two: assert property (!halt_active && !fast_slow && div_sel == 3'h7 && fast_tick
                                 && fdiv_cnt_ff[0] |-> sys_clock_en)
    else $error("divide by two tick missing");

  a_slow_pins_free: assert property (!sel_xtal && !active_xtal_ff |-> slow_crystal_pins_gpio && !osc_enable.slow_xtal)
    else $error("slow crystal pins held while unused");

  a_fast_pins_free: assert property (!cfg_fast_xtal |-> fast_crystal_pins_gpio && !osc_enable.fast_xtal)
    else $error("fast crystal pins held with fast RC");

  a_halt_stops_sys: assert property (halt_active && !idle1 |-> !sys_clock_en)
    else $error("system clock ran while halted");

  a_switch_no_glitch: assert property (seq_switch_begin |-> !sub_clock_en)
    else $error("sub clock tick during a source switch");

  a_timers_fed: assert property (sub_clock_en && wdt_enabled |-> wdt_clock_en)
    else $error("watchdog clock missing");

  a_mode_write: assert property (wr_mode |=> fast_slow == $past(avs_writedata[0]))
    else $error("fast slow select not updated");

endmodule : oscillator_source_select
`default_nettype wire

// ===== testbench/osc_tick_model.sv
// Purpose: Behavioural oscillators that send tick pulses while they are enabled.
// Assumes: Periods in clk cycles are far shorter than the real ones, to keep runs brief.
// Notes: A disabled oscillator sends no ticks, just as a stopped real one would.
`timescale 1ns/100ps
`default_nettype none
module osc_tick_model import osc_select_pkg::*; #(
  parameter int FAST_RC_PER = 2,
  parameter int FAST_XTAL_PER = 3,
  parameter int SLOW_RC_PER = 16,
  parameter int SLOW_XTAL_PER = 20
) (
  input wire logic clk, // System clock
  input wire logic srst, // Synchronous reset
  input wire osc_set_type osc_enable, // Oscillator enables
  output osc_set_type osc_tick // Tick pulses
);
  localparam int PER [4] = '{SLOW_XTAL_PER, SLOW_RC_PER, FAST_XTAL_PER, FAST_RC_PER};
  int cnt_ff [4];

  // Low power only stretches start-up, so the running period ignores it
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (srst || !osc_enable[i]) begin
        cnt_ff[i] <= 0;
        osc_tick[i] <= 1'b0;
      end else begin
        cnt_ff[i] <= (cnt_ff[i] == PER[i] - 1) ? 0 : cnt_ff[i] + 1;
        osc_tick[i] <= (cnt_ff[i] == PER[i] - 1);
      end
    end
  end
endmodule : osc_tick_model
`default_nettype wire

// ===== testbench/test_oscillator_source_select.sv
// Purpose: Self-checking bench for the oscillator source selection block.
// Assumes: Ticks come from osc_tick_model; crystal ready count cut to 8 ticks.
// Notes: Clock counts are compared with a small tolerance for divider phase.
`timescale 1ns/100ps
`default_nettype none
module test_oscillator_source_select import osc_select_pkg::*;;
  localparam int XR = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  osc_set_type osc_tick;
  osc_set_type osc_enable;
  logic halt_active = 1'b0;
  logic fsys_keep = 1'b0;
  logic wdt_enabled = 1'b0;
  logic low_power, xtal_gpio, fast_gpio, high_range, sys_en, sub_en, wdt_en, tb_en, ready, reset_req;
  logic [7:0] bad [4] = '{8'h00, 8'h7f, 8'h2b, 8'hd4};
  logic [31:0] rd;
  int mismatches = 0;
  int comparisons = 0;
  int reset_pulses = 0;
  int n_sys, n_sub, n_wdt, n_tb, n_fast, t1, t2;

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  // Reset requests are counted, since each lasts one cycle
  always @(posedge clk) if (reset_req === 1'b1) reset_pulses <= reset_pulses + 1;

  oscillator_source_select #(.XTAL_READY(XR), .RC_READY(SLOW_RC_READY_CYCLES)) uut (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .osc_tick(osc_tick), .halt_active(halt_active),
    .fsys_keep(fsys_keep), .wdt_enabled(wdt_enabled), .osc_enable(osc_enable),
    .slow_crystal_low_power_sel(low_power), .slow_crystal_pins_gpio(xtal_gpio),
    .fast_crystal_pins_gpio(fast_gpio), .fast_xtal_high_range(high_range), .sys_clock_en(sys_en),
    .sub_clock_en(sub_en), .wdt_clock_en(wdt_en), .timebase_clock_en(tb_en),
    .slow_osc_ready_flag(ready), .mcu_reset_req(reset_req));

  osc_tick_model osc (.clk(clk), .srst(srst), .osc_enable(osc_enable), .osc_tick(osc_tick));

  // Verdict and end of run
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Exact comparison of a design value
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  // Comparison of a count, allowing for divider phase
  task automatic check_near(input string name, input int exp, input int got, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_near

  // One Avalon transfer; the request is held until waitrequest is seen low
  task automatic access(input logic wr, input logic [3:0] addr, input logic [7:0] data, input logic [3:0] be);
    int i;
    @(posedge clk);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= addr;
    avs_writedata <= {24'h0, data};
    avs_byteenable <= be;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 16) begin
      mismatches++;
      $display("wrong value waitrequest expected 0 seen 1");
      final_report();
    end
  endtask : access

  // The write lands at the ending edge, so outputs are looked at one edge later
  task automatic wr(input logic [3:0] addr, input logic [7:0] data);
    access(1'b1, addr, data, 4'h1);
    @(posedge clk);
  endtask : wr

  task automatic rdchk(input string name, input logic [3:0] addr, input logic [31:0] exp);
    access(1'b0, addr, 8'h00, 4'h1);
    check_val(name, exp, rd);
  endtask : rdchk

  // Counts clock enables and fast ticks over n cycles
  task automatic count(input int n);
    n_sys = 0;
    n_sub = 0;
    n_wdt = 0;
    n_tb = 0;
    n_fast = 0;
    repeat (n) begin
      @(posedge clk);
      n_sys += int'(sys_en === 1'b1);
      n_sub += int'(sub_en === 1'b1);
      n_wdt += int'(wdt_en === 1'b1);
      n_tb += int'(tb_en === 1'b1);
      n_fast += int'(osc_tick.fast_rc === 1'b1);
    end
  endtask : count

  // Waits for the ready flag level, counting ticks of the chosen slow source only,
  // since the old source keeps ticking while a switch is pending
  task automatic wait_ready(input logic lvl, input int bound, input logic xtal, output int ticks);
    int i;
    ticks = 0;
    for (i = 0; i < bound; i++) begin
      @(posedge clk);
      if (ready === lvl) break;
      ticks += int'((xtal ? osc_tick.slow_xtal : osc_tick.slow_rc) === 1'b1);
    end
    if (i == bound) begin
      mismatches++;
      $display("wrong value ready flag expected %b seen %b", lvl, ready);
      final_report();
    end
  endtask : wait_ready

  // Main sequence of tests
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    rdchk("sub ctrl reset", SUB_CTRL_OFFSET, 32'h2a);
    rdchk("options reset", CLK_CFG_OFFSET, 32'h00);
    access(1'b0, SYS_MODE_OFFSET, 8'h00, 4'h1);
    check_val("mode reset", 32'h03, rd & 32'hf3);
    check_val("low power reset", 32'h0, low_power);
    check_val("one slow source", 32'h1, osc_enable.slow_rc ^ osc_enable.slow_xtal);
    check_val("one fast source", 32'h1, osc_enable.fast_rc ^ osc_enable.fast_xtal);
    $display("test reset values done");
    wr(SUB_CTRL_OFFSET, 8'haa);
    rdchk("low power set", SUB_CTRL_OFFSET, 32'haa);
    check_val("low power out", 32'h1, low_power);
    wr(SUB_CTRL_OFFSET, 8'h2a);
    check_val("low power clear", 32'h0, low_power);
    access(1'b1, SUB_CTRL_OFFSET, 8'hd5, 4'he);
    rdchk("lane off ignored", SUB_CTRL_OFFSET, 32'h2a);
    wr(4'hc, 8'hff);
    rdchk("unmapped", 4'hc, 32'h0);
    $display("test register access done");
    foreach (bad[k]) begin
      t1 = reset_pulses;
      wr(SYS_MODE_OFFSET, 8'h22);
      wr(SUB_CTRL_OFFSET, bad[k]);
      repeat (3) @(posedge clk);
      check_near("reset pulses", t1 + 1, reset_pulses, 0);
      rdchk("code not stored", SUB_CTRL_OFFSET, 32'h2a);
      access(1'b0, SYS_MODE_OFFSET, 8'h00, 4'h1);
      check_val("mode after reset", 32'h03, rd & 32'hf3);
    end
    $display("test illegal codes done");
    for (int c = 0; c < 8; c++) begin
      wr(SYS_MODE_OFFSET, {c[2:0], 5'h00});
      count(1024);
      if (c < 2) check_near("sub as system", n_sub, n_sys, 1);
      else check_near("divided system", n_fast, n_sys * (1 << (8 - c)), 2 * (1 << (8 - c)));
    end
    wr(SYS_MODE_OFFSET, 8'h03);
    count(512);
    check_near("fast undivided", n_fast, n_sys, 1);
    $display("test divider done");
    wr(CLK_CFG_OFFSET, 8'hff);
    rdchk("options", CLK_CFG_OFFSET, 32'h03);
    check_val("high range", 32'h1, high_range);
    check_val("fast pins", 32'h0, fast_gpio);
    check_val("fast crystal on", 32'h1, {osc_enable.fast_rc, osc_enable.fast_xtal});
    wr(CLK_CFG_OFFSET, 8'h01);
    check_val("low range", 32'h0, high_range);
    wr(CLK_CFG_OFFSET, 8'h00);
    check_val("fast pins free", 32'h1, fast_gpio);
    $display("test clock options done");
    wr(SUB_CTRL_OFFSET, 8'h55);
    wait_ready(1'b0, 20, 1'b1, t1);
    wait_ready(1'b1, 3000, 1'b1, t2);
    check_near("crystal ready ticks", XR + 1, t1 + t2, 1);
    check_val("crystal pins", 32'h0, xtal_gpio);
    check_val("crystal source", 32'h1, {osc_enable.slow_rc, osc_enable.slow_xtal});
    // Software lowers crystal current only once the crystal is up and ready
    wr(SUB_CTRL_OFFSET, 8'hd5);
    check_val("crystal low power", 32'h1, low_power);
    count(400);
    check_near("crystal runs", 20, n_sub, 2);
    wr(SUB_CTRL_OFFSET, 8'h2a);
    wait_ready(1'b0, 20, 1'b0, t1);
    wait_ready(1'b1, 3000, 1'b0, t2);
    check_near("rc ready ticks", SLOW_RC_READY_CYCLES + 1, t1 + t2, 1);
    check_val("crystal pins free", 32'h1, xtal_gpio);
    $display("test sub source switch done");
    wr(SYS_MODE_OFFSET, 8'h01);
    halt_active <= 1'b1;
    count(400);
    check_near("sleep system", 0, n_sys, 0);
    check_near("sleep time base", 0, n_tb, 0);
    check_val("sleep ready", 32'h0, ready);
    halt_active <= 1'b0;
    wait_ready(1'b1, 3000, 1'b0, t1);
    wr(SYS_MODE_OFFSET, 8'h03);
    fsys_keep <= 1'b1;
    halt_active <= 1'b1;
    count(400);
    check_near("idle1 system", n_fast, n_sys, 1);
    check_near("idle time base", n_sub, n_tb, 0);
    fsys_keep <= 1'b0;
    count(400);
    check_near("idle0 system", 0, n_sys, 0);
    halt_active <= 1'b0;
    wdt_enabled <= 1'b1;
    count(400);
    check_near("watchdog clock", n_sub, n_wdt, 0);
    check_near("time base clock", n_sub, n_tb, 0);
    check_near("sub running", 25, n_sub, 2);
    // Halt with the watchdog on keeps the sub clock for the watchdog only
    wr(SYS_MODE_OFFSET, 8'h01);
    halt_active <= 1'b1;
    count(400);
    check_near("sleep1 watchdog", 25, n_wdt, 2);
    check_near("sleep1 time base", 0, n_tb, 0);
    check_near("sleep1 system", 0, n_sys, 0);
    halt_active <= 1'b0;
    $display("test halt modes done");
    final_report();
  end
endmodule : test_oscillator_source_select
`default_nettype wire
